//--- core/std_timer.sv
// Sixteen-bit standard timer with compare, timer and PWM modes.
//
// Overview of operation
// R1: Clear select picks comparator A or P/overflow.
// R2: Overflow clearing only when period value zero.
// R3: Clear select ignored in PWM mode.
// R4: Count readable as two read-only bytes.
// R5: Comparator A value in two RW bytes.
// R6: Period byte compared with count high byte.
// R7: Compare mode, select low: both flags set.
// R8: Select high: only flag A, never P.
// R9: Software keeps A nonzero in compare mode.
// R10: A zero: wrap at maximum, no A flag.
// R11: Pin changes only on comparator A match.
// R12: Pin action: none, low, high, toggle.
// R13: Run rising edge loads initial pin level.
// R14: Timer mode as compare, pin not driven.
// R15: PWM: one value period, other duty.
// R16: PWM mode raises both match flags.
// R17: PWM polarity, force levels, output invert.
// R18: Swap low: period from period byte.
// R19: Duty at or above period: fully active.
// R20: Swap high: A sets period, byte duty.
// R21: PWM counting runs while pin forced.
// R22: Pin action codes 00,01,10,11 as listed.
// R23: Run rise clears count, fall holds it.
// R24: Pause holds count, resumes afterwards.
// R25: Count up once per counting clock tick.
`timescale 1ns/100ps
module std_timer
    import std_timer_pkg::*;
(
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Counting clock tick from the clock selector.
    input wire logic count_tick,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Output pin and its enable.
    output logic timer_pin,
    output logic timer_pin_oe,
    // One-cycle match events.
    output logic match_a_event,
    output logic match_p_event
);

    // All state of the block in one record.
    typedef struct packed {
        logic pause;
        logic run;
        logic [7:0] ctrl1;
        logic [15:0] cnt;
        logic [15:0] cmpa;
        logic [7:0] period;
        logic flag_a;
        logic flag_p;
        logic pin_lvl;
        logic pwm_act;
        logic [7:0] rdata;
        logic pin;
        logic pin_oe;
        logic ev_a;
        logic ev_p;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Decoded control fields.
    mode_t mode;
    logic [1:0] pin_act;
    logic cclr;
    logic pwm_mode;
    logic run_rise;
    logic counting;
    logic cnt_max;
    logic match_a;
    logic match_p;
    logic clr_cnt;
    logic [16:0] duty_len;
    logic [16:0] per_len;
    logic [16:0] pos;

    assign mode = mode_t'(s_q.ctrl1[BIT_MODE_HI:BIT_MODE_LO]);
    assign pin_act = s_q.ctrl1[BIT_PIN_HI:BIT_PIN_LO];
    assign cclr = s_q.ctrl1[BIT_CCLR];
    assign pwm_mode = (mode == MODE_PWM);
    assign run_rise = reg_wr && (reg_addr == OFS_CTRL0)
        && reg_wdata[BIT_RUN] && !s_q.run;
    // A tick that the counter takes; the assertions below lean on it.
    assign counting = s_q.run && !s_q.pause && count_tick;

    // Comparators see the count that the tick is about to leave.
    always_comb begin
        cnt_max = (s_q.cnt == 16'hFFFF);
        // A zero compare value never matches, so the count wraps. [R10]
        match_a = (s_q.cmpa != RST_WORD)
            && (s_q.cnt == (s_q.cmpa - 16'h0001)); // [R5]
        // Period byte against the high byte; zero means a full wrap. [R6]
        if (s_q.period == RST_BYTE) begin
            match_p = cnt_max; // [R2]
        end else begin
            match_p = (s_q.cnt[15:8] == (s_q.period - 8'h01))
                && (s_q.cnt[7:0] == 8'hFF);
        end
        // PWM ignores the clear select; swap decides the period source.
        if (pwm_mode) begin // [R3] [R15]
            clr_cnt = s_q.ctrl1[BIT_SWAP] ? (match_a || cnt_max)
                : match_p; // [R18] [R20]
        end else if (cclr) begin
            clr_cnt = match_a || cnt_max; // [R1] [R10]
        end else begin
            clr_cnt = match_p; // [R1] [R2]
        end
    end

    // PWM lengths in counting clocks, zero period byte meaning 65536.
    always_comb begin
        per_len = {1'b0, s_q.cmpa};
        duty_len = {1'b0, s_q.cmpa}; // [R18]
        if (s_q.period == RST_BYTE) begin
            pos = 17'h10000;
        end else begin
            pos = {1'b0, s_q.period, 8'h00};
        end
        if (s_q.ctrl1[BIT_SWAP]) begin
            duty_len = pos; // [R20]
        end else begin
            per_len = pos;
        end
        if (per_len == 17'h00000) begin
            per_len = 17'h10000;
        end
    end

    // Next-state logic for counter, registers, flags and pin.
    always_comb begin
        s_d = s_q;
        s_d.ev_a = 1'b0;
        s_d.ev_p = 1'b0;
        // Register writes; count bytes are read-only. [R4]
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL0: begin
                    s_d.pause = reg_wdata[BIT_PAUSE];
                    s_d.run = reg_wdata[BIT_RUN];
                end
                OFS_CTRL1: s_d.ctrl1 = reg_wdata;
                OFS_CMPA_LO: s_d.cmpa[7:0] = reg_wdata; // [R5]
                OFS_CMPA_HI: s_d.cmpa[15:8] = reg_wdata; // [R5]
                OFS_PERIOD: s_d.period = reg_wdata;
                OFS_FLAGS: begin
                    // Writing one clears a flag; a new match below wins.
                    if (reg_wdata[BIT_FLAG_A]) begin
                        s_d.flag_a = 1'b0;
                    end
                    if (reg_wdata[BIT_FLAG_P]) begin
                        s_d.flag_p = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (run_rise) begin
            s_d.cnt = RST_WORD; // [R23]
            s_d.pin_lvl = s_q.ctrl1[BIT_INIT]; // [R13]
            s_d.pwm_act = 1'b1;
        end else if (s_q.run && !s_q.pause && count_tick) begin // [R24]
            // Counting; the fall of run simply stops ticks here. [R23]
            s_d.cnt = clr_cnt ? RST_WORD : s_q.cnt + 16'h0001; // [R25]
            if (pwm_mode) begin
                // Both comparators flag in PWM mode. [R16] [R21]
                s_d.ev_a = match_a;
                s_d.ev_p = match_p;
                // Active from period start until the duty count. [R19]
                if (clr_cnt) begin
                    s_d.pwm_act = (duty_len != 17'h00000);
                end else if ({1'b0, s_q.cnt} + 17'h00001 >= duty_len) begin
                    s_d.pwm_act = (duty_len >= per_len);
                end
            end else begin
                s_d.ev_a = match_a; // [R7] [R14]
                s_d.ev_p = match_p && !cclr; // [R7] [R8]
                if (match_a && mode == MODE_COMPARE) begin // [R11]
                    case (pin_act) // [R12] [R22]
                        PIN_KEEP: s_d.pin_lvl = s_q.pin_lvl;
                        PIN_LOW: s_d.pin_lvl = 1'b0;
                        PIN_HIGH: s_d.pin_lvl = 1'b1;
                        PIN_TOGGLE: s_d.pin_lvl = !s_q.pin_lvl;
                        default: s_d.pin_lvl = s_q.pin_lvl;
                    endcase
                end
            end
        end
        // Flags: the hardware set overrides a same-cycle clear.
        if (s_d.ev_a) begin
            s_d.flag_a = 1'b1;
        end
        if (s_d.ev_p) begin
            s_d.flag_p = 1'b1;
        end
        // Pin drive per mode; timer mode leaves the pin free. [R14]
        case (mode)
            MODE_COMPARE: begin
                s_d.pin = s_d.pin_lvl;
                s_d.pin_oe = 1'b1;
            end
            MODE_PWM: begin
                // Forced levels, polarity then invert. [R17] [R21]
                case (pin_act)
                    PWM_FORCE_OFF: s_d.pin = !s_q.ctrl1[BIT_INIT];
                    PWM_FORCE_ON: s_d.pin = s_q.ctrl1[BIT_INIT];
                    default: s_d.pin = s_d.pwm_act
                        ? s_q.ctrl1[BIT_INIT] : !s_q.ctrl1[BIT_INIT];
                endcase
                s_d.pin = s_d.pin ^ s_q.ctrl1[BIT_INV];
                s_d.pin_oe = 1'b1;
            end
            default: begin
                s_d.pin = 1'b0;
                s_d.pin_oe = 1'b0;
            end
        endcase
        // Invert applies in compare mode too.
        if (mode == MODE_COMPARE) begin
            s_d.pin = s_d.pin_lvl ^ s_q.ctrl1[BIT_INV];
        end
        // Read data stands the cycle after the read strobe.
        s_d.rdata = RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL0: s_d.rdata = {s_q.pause, 3'h0, s_q.run, 3'h0};
                OFS_CTRL1: s_d.rdata = s_q.ctrl1;
                OFS_CNT_LO: s_d.rdata = s_q.cnt[7:0]; // [R4]
                OFS_CNT_HI: s_d.rdata = s_q.cnt[15:8]; // [R4]
                OFS_CMPA_LO: s_d.rdata = s_q.cmpa[7:0];
                OFS_CMPA_HI: s_d.rdata = s_q.cmpa[15:8];
                OFS_PERIOD: s_d.rdata = s_q.period;
                OFS_FLAGS: s_d.rdata = {6'h00, s_q.flag_p, s_q.flag_a};
                default: s_d.rdata = RST_BYTE;
            endcase
        end
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign timer_pin = s_q.pin;
    assign timer_pin_oe = s_q.pin_oe;
    assign match_a_event = s_q.ev_a;
    assign match_p_event = s_q.ev_p;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // A run rising edge restarts the count from zero.
    AST_RUN_CLEARS: assert property ( // [R23]
        clk_en && run_rise |=> s_q.cnt == RST_WORD)
        else $error("Run rise did not clear the count.");

    // The initial level follows the init bit of control byte one at start.
    AST_INIT_LEVEL: assert property ( // [R13]
        clk_en && run_rise && mode == MODE_COMPARE
        |=> s_q.pin_lvl == $past(s_q.ctrl1[BIT_INIT]))
        else $error("Initial pin level not loaded.");

    // Outside PWM mode no period event may leave the block with clear select high.
    AST_NO_P_FLAG: assert property ( // [R8]
        clk_en && !pwm_mode && cclr |=> !match_p_event)
        else $error("Period flag raised with clear select high.");

    // A zero compare value never produces an A event.
    AST_A_ZERO: assert property ( // [R10]
        clk_en && s_q.cmpa == RST_WORD |=> !match_a_event)
        else $error("Zero compare value matched.");

    // Pause freezes the count whatever the ticks do.
    AST_PAUSE: assert property ( // [R24]
        clk_en && s_q.pause && !run_rise |=> $stable(s_q.cnt))
        else $error("Count moved while paused.");

    // Timer mode leaves the pin free for other functions.
    AST_TIMER_PIN: assert property ( // [R14]
        clk_en && mode == MODE_TIMER |=> !timer_pin_oe)
        else $error("Pin driven in timer mode.");

    // Each counting tick without a clear adds one.
    AST_COUNT_UP: assert property ( // [R25]
        clk_en && counting && !clr_cnt && !reg_wr
        |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("Count did not advance.");

    // Without an A match the compare pin level holds.
    AST_PIN_ONLY_A: assert property ( // [R11]
        clk_en && mode == MODE_COMPARE && !match_a && !run_rise
        |=> $stable(s_q.pin_lvl))
        else $error("Pin level changed without a match.");

    // Outside PWM mode a period match clears the count when clear select is low.
    AST_P_CLEAR: assert property ( // [R1]
        clk_en && counting && !pwm_mode && !cclr && match_p && !run_rise
        |=> s_q.cnt == RST_WORD)
        else $error("Period match did not clear.");

    // The hardware set of a flag wins over a same-cycle clear.
    AST_FLAG_A_SET: assert property ( // [R7]
        match_a_event |-> s_q.flag_a)
        else $error("Flag A lost beside its event.");

    AST_FLAG_P_SET: assert property ( // [R7]
        match_p_event |-> s_q.flag_p)
        else $error("Flag P lost beside its event.");

    // PWM mode reports every period match as an event.
    AST_PWM_P_EVENT: assert property ( // [R16]
        clk_en && counting && pwm_mode && match_p
        |=> match_p_event)
        else $error("Period match lost in PWM mode.");

    // Duty at or above the period keeps the PWM active throughout.
    AST_PWM_FULL: assert property ( // [R19]
        clk_en && pwm_mode && s_q.pwm_act && duty_len >= per_len
        |=> s_q.pwm_act)
        else $error("PWM left its active state at full duty.");

    // A toggle action inverts the pin level on each A match.
    AST_TOGGLE: assert property ( // [R12]
        clk_en && counting && mode == MODE_COMPARE && match_a
        && pin_act == PIN_TOGGLE |=> s_q.pin_lvl != $past(s_q.pin_lvl))
        else $error("Toggle action did not invert the pin.");

    // Main scenarios that the bench is meant to reach.
    COV_MATCH_A: cover property (s_q.ev_a);
    COV_MATCH_P: cover property (s_q.ev_p);
    COV_PWM_ON: cover property (pwm_mode && s_q.pin_oe && s_q.pwm_act);
    COV_TOGGLE: cover property (pin_act == PIN_TOGGLE && s_d.ev_a);
    COV_WRAP: cover property (counting && cnt_max);

endmodule

//--- core/std_timer_pkg.sv
// Package with register map, field positions and encodings of the timer.
package std_timer_pkg;
    // Register offsets on the byte register port.
    localparam logic [2:0] OFS_CTRL0 = 3'h0;
    localparam logic [2:0] OFS_CTRL1 = 3'h1;
    localparam logic [2:0] OFS_CNT_LO = 3'h2;
    localparam logic [2:0] OFS_CNT_HI = 3'h3;
    localparam logic [2:0] OFS_CMPA_LO = 3'h4;
    localparam logic [2:0] OFS_CMPA_HI = 3'h5;
    localparam logic [2:0] OFS_PERIOD = 3'h6;
    localparam logic [2:0] OFS_FLAGS = 3'h7;
    // Control byte zero fields.
    localparam int BIT_PAUSE = 7;
    localparam int BIT_RUN = 3;
    // Control byte one fields.
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_PIN_HI = 5;
    localparam int BIT_PIN_LO = 4;
    localparam int BIT_INIT = 3;
    localparam int BIT_INV = 2;
    localparam int BIT_SWAP = 1;
    localparam int BIT_CCLR = 0;
    // Flag byte fields.
    localparam int BIT_FLAG_A = 0;
    localparam int BIT_FLAG_P = 1;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Operating modes.
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } mode_t;
    // Pin action encodings in compare-match mode.
    localparam logic [1:0] PIN_KEEP = 2'b00;
    localparam logic [1:0] PIN_LOW = 2'b01;
    localparam logic [1:0] PIN_HIGH = 2'b10;
    localparam logic [1:0] PIN_TOGGLE = 2'b11;
    // Pin action encodings in PWM mode.
    localparam logic [1:0] PWM_FORCE_OFF = 2'b00;
    localparam logic [1:0] PWM_FORCE_ON = 2'b01;
endpackage

//--- verif/std_timer_tb.sv
// Self-checking testbench for the sixteen-bit standard timer.
`timescale 1ns/100ps
module std_timer_tb;
    import std_timer_pkg::*;
    logic mclk, sys_rst, clk_en, count_tick, reg_wr, reg_rd, rd_q;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic timer_pin, timer_pin_oe, match_a_event, match_p_event;
    logic [7:0] exp_q[$];
    logic [7:0] pw_c[5] = '{8'hA9, 8'h88, 8'h9C, 8'hAC, 8'hAA};
    logic [4:0] pw_e1 = 5'h11;
    logic [4:0] pw_e2 = 5'h01;
    int num_errors = 0, tests_run = 0, na = 0, np = 0, cyc = 0;
    int a0, p0, ticks;
    logic [15:0] v, cnt;

    std_timer dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .count_tick(count_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_pin(timer_pin), .timer_pin_oe(timer_pin_oe),
        .match_a_event(match_a_event), .match_p_event(match_p_event));

    // Free-running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(string what, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_rd(logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH reg_rdata expected %h seen %h", e, g);
        end
    endtask

    // Event counting and the hang guard; one pulse is one event.
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        cyc <= cyc + 1;
        if (!sys_rst && match_a_event === 1'b1) na <= na + 1;
        if (!sys_rst && match_p_event === 1'b1) np <= np + 1;
        if (cyc == 90000) begin
            num_errors++;
            test_done();
        end
    end

    // Read data stand only in the cycle after the strobe, so look there.
    always @(negedge mclk) begin
        if (rd_q === 1'b1) chk_rd(exp_q.pop_front(), reg_rdata);
    end

    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [2:0] a, logic [7:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask

    // Ticks are counted as driven; three cycles let events reach counters.
    task automatic tick(int n, bit rnd);
        logic t;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            t = rnd ? 1'($urandom) : 1'b1;
            count_tick <= t;
            ticks += int'(t);
        end
        @(posedge mclk);
        count_tick <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    // Mode changes are made with the timer off, then a run rising edge.
    task automatic start(logic [7:0] c1);
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, c1);
        wr(OFS_CTRL0, 8'h08);
        repeat (3) @(negedge mclk);
        a0 = na;
        p0 = np;
    endtask

    // Main sequence.
    initial begin
        {sys_rst, clk_en} = 2'b11;
        {count_tick, reg_wr, reg_rd} = 3'h0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        void'($urandom(49340));
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 8; k++) rd(3'(k), 8'h00);
        v = 16'($urandom);
        wr(OFS_CMPA_LO, v[7:0]);
        wr(OFS_CMPA_HI, v[15:8]);
        wr(OFS_CNT_LO, 8'hA5);
        wr(OFS_CNT_HI, 8'h5A);
        rd(OFS_CMPA_LO, v[7:0]);
        rd(OFS_CMPA_HI, v[15:8]);
        rd(OFS_CNT_LO, 8'h00);
        rd(OFS_CNT_HI, 8'h00);
        $display("Test registers finished");
        // A large comparator A value keeps the count free of clears.
        v = 16'($urandom) | 16'h8000;
        wr(OFS_CMPA_LO, v[7:0]);
        wr(OFS_CMPA_HI, v[15:8]);
        start(8'hC1);
        ticks = 0;
        tick(200, 1'b1);
        cnt = 16'(ticks);
        rd(OFS_CNT_LO, cnt[7:0]);
        rd(OFS_CNT_HI, cnt[15:8]);
        @(negedge mclk);
        chk_val("pin enable", 16'h0000, 16'(timer_pin_oe));
        wr(OFS_CTRL0, 8'h88);
        tick(50, 1'b0);
        rd(OFS_CNT_LO, cnt[7:0]);
        wr(OFS_CTRL0, 8'h08);
        tick(30, 1'b0);
        cnt = cnt + 16'h001E;
        rd(OFS_CNT_LO, cnt[7:0]);
        // Ticks while the clock enable is low must leave the count alone.
        @(posedge mclk);
        clk_en <= 1'b0;
        tick(40, 1'b0);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(OFS_CNT_LO, cnt[7:0]);
        wr(OFS_CTRL0, 8'h00);
        tick(20, 1'b0);
        rd(OFS_CNT_LO, cnt[7:0]);
        wr(OFS_CTRL0, 8'h08);
        rd(OFS_CNT_LO, 8'h00);
        $display("Test counting finished");
        // Period byte below comparator A, toggling pin from a high start.
        wr(OFS_CMPA_LO, 8'h04);
        wr(OFS_CMPA_HI, 8'h01);
        wr(OFS_PERIOD, 8'h01);
        start(8'h39);
        chk_val("initial pin", 16'h0001, 16'(timer_pin));
        tick(780, 1'b0);
        chk_val("a events", 16'h0003, 16'(na - a0));
        chk_val("p events", 16'h0000, 16'(np - p0));
        chk_val("pin", 16'h0000, 16'(timer_pin));
        rd(OFS_FLAGS, 8'h01);
        wr(OFS_FLAGS, 8'h03);
        start(8'h38);
        tick(512, 1'b0);
        chk_val("a events", 16'h0000, 16'(na - a0));
        chk_val("p events", 16'h0002, 16'(np - p0));
        chk_val("pin", 16'h0001, 16'(timer_pin));
        rd(OFS_CNT_HI, 8'h00);
        rd(OFS_FLAGS, 8'h02);
        $display("Test compare finished");
        // Every pin action code, then timer mode with the same match.
        wr(OFS_CMPA_LO, 8'h02);
        wr(OFS_CMPA_HI, 8'h00);
        for (int k = 0; k < 4; k++) begin
            start(8'h09 | 8'(k << 4));
            tick(2, 1'b0);
            v = (k == 1 || k == 3) ? 16'h0000 : 16'h0001;
            chk_val("pin action", v, 16'(timer_pin));
            chk_val("pin enable", 16'h0001, 16'(timer_pin_oe));
        end
        start(8'hF9);
        tick(2, 1'b0);
        chk_val("pin enable", 16'h0000, 16'(timer_pin_oe));
        chk_val("a events", 16'h0001, 16'(na - a0));
        $display("Test pin actions finished");
        // Comparator A left at zero only in timer mode, never compare mode.
        wr(OFS_CMPA_LO, 8'h00);
        wr(OFS_PERIOD, 8'h00);
        start(8'hC0);
        tick(65536, 1'b0);
        chk_val("a events", 16'h0000, 16'(na - a0));
        chk_val("p events", 16'h0001, 16'(np - p0));
        rd(OFS_CNT_HI, 8'h00);
        $display("Test overflow finished");
        // PWM with duty above period, forced levels, invert and swap.
        wr(OFS_CMPA_HI, 8'h02);
        wr(OFS_PERIOD, 8'h01);
        for (int k = 0; k < 5; k++) begin
            start(pw_c[k]);
            tick(100, 1'b0);
            chk_val("pwm pin", 16'(pw_e1[k]), 16'(timer_pin));
            tick(200, 1'b0);
            chk_val("pwm pin", 16'(pw_e2[k]), 16'(timer_pin));
            chk_val("p events", 16'h0001, 16'(np - p0));
            chk_val("a events", 16'h0000, 16'(na - a0));
        end
        $display("Test pwm finished");
        repeat (4) @(negedge mclk);
        test_done();
    end
endmodule
